// File: csm_pkg.sv
// package for the cyclic setpoint and step-direction mode block
`default_nettype none
package csm_pkg;
  localparam logic [7:0]  MODE_CSV         = 8'h09;
  localparam logic [7:0]  MODE_CST         = 8'h0a;
  localparam logic [7:0]  MODE_STEP        = 8'hff;
  localparam logic [11:0] ADDR_MODE        = 12'h000;
  localparam logic [11:0] ADDR_CTRL        = 12'h004;
  localparam logic [11:0] ADDR_STATUS      = 12'h008;
  localparam logic [11:0] ADDR_PERIOD      = 12'h00c;
  localparam logic [11:0] ADDR_TIME_INDEX  = 12'h010;
  localparam logic [11:0] ADDR_TARGET      = 12'h014;
  localparam logic [11:0] ADDR_MAX_TORQUE  = 12'h018;
  localparam logic [11:0] ADDR_NUMER       = 12'h01c;
  localparam logic [11:0] ADDR_DENOM       = 12'h020;
  localparam logic [11:0] ADDR_SUBTYPE     = 12'h024;
  localparam logic [11:0] ADDR_POSITION    = 12'h028;
  localparam logic [11:0] ADDR_SETPOINT    = 12'h02c;
  localparam logic [11:0] ADDR_FERR_TMO    = 12'h030;
  localparam logic [31:0] NUMER_RESET      = 32'h00000080;
  localparam logic [31:0] DENOM_RESET      = 32'h00000001;
  localparam logic [7:0]  TIME_INDEX_RESET = 8'hfd;
  localparam logic [7:0]  TIME_INDEX_MS    = 8'hfd;
  localparam logic [15:0] PERIOD_RESET     = 16'h0001;
  localparam logic [15:0] FERR_TMO_RESET   = 16'h0064;
  localparam int          CLK_MHZ          = 250;
  localparam int          MS_BASE_US       = 1000;
  localparam int          MS_CYCLES        = CLK_MHZ * MS_BASE_US;
  localparam int          SW_SYNC          = 8;
  localparam int          SW_FOLLOW        = 12;
  localparam int          SW_FERR          = 13;
  localparam logic [1:0]  CTRL_CLOSED_LOOP = 2'h0;
  typedef enum logic [1:0] {
    CSM_IDLE = 2'b00,
    CSM_CSV  = 2'b01,
    CSM_CST  = 2'b10,
    CSM_STEP = 2'b11
  } csm_mode_t;
  typedef struct packed {
    logic        dir;
    logic        step;
  } csm_step_t;
endpackage : csm_pkg
`default_nettype wire

// File: csm_top.sv
// operating-mode logic: cyclic velocity/torque and step-direction
//
// The APB slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module csm_top
  import csm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PULSE_IN,
  input  wire logic        DIR_IN,
  input  wire logic        BUS_SYNC,
  input  wire logic        LIMIT_NEG,
  input  wire logic        LIMIT_POS,
  input  wire logic        FERR_OUTSIDE,
  output logic      [1:0]  MODE,
  output logic      [15:0] STATUS_WORD,
  output logic      [31:0] SETPOINT,
  output logic             SETPOINT_VALID,
  output logic             CYCLE_TICK,
  output logic             LIMIT_STOP,
  output logic      [31:0] POSITION
);
  logic [7:0]  mode_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] period_reg;
  logic [7:0]  index_reg;
  logic [31:0] target_reg;
  logic [31:0] max_torque_reg;
  logic [31:0] numer_reg;
  logic [31:0] denom_reg;
  logic        subtype_reg;
  logic [15:0] ferr_tmo_reg;
  logic [31:0] position_reg;
  logic [31:0] setpoint_reg;
  logic        setpoint_valid_reg;
  logic        written_reg;
  logic        follow_reg;
  logic        ferr_reg;
  logic [31:0] ms_cnt_reg;
  logic        ms_tick;
  logic [15:0] cyc_cnt_reg;
  logic        cyc_tick;
  logic [15:0] ferr_cnt_reg;
  logic [31:0] frac_reg;
  logic [1:0]  pulse_sync_reg;
  logic [1:0]  dir_sync_reg;
  logic [1:0]  bsync_sync_reg;
  logic [1:0]  lneg_sync_reg;
  logic [1:0]  lpos_sync_reg;
  logic [1:0]  fout_sync_reg;
  logic        pulse_d_reg;
  logic        dir_d_reg;
  logic        in_sync_reg;
  csm_mode_t   mode_st;
  csm_step_t   step_ev;
  logic        closed_loop;
  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rd_data;
  logic [31:0] width_next;

  function automatic csm_mode_t decode_mode(input logic [7:0] code);
    case (code)
      MODE_CSV:  decode_mode = CSM_CSV;
      MODE_CST:  decode_mode = CSM_CST;
      MODE_STEP: decode_mode = CSM_STEP;
      default:   decode_mode = CSM_IDLE;
    endcase
  endfunction : decode_mode

  // control word has only the closed-loop enable here; no mode bits
  assign closed_loop = ctrl_reg[CTRL_CLOSED_LOOP];
  // torque mode falls back to idle without closed loop
  always_comb begin
    mode_st = decode_mode(mode_reg);
    if (mode_st == CSM_CST && !closed_loop) begin
      mode_st = CSM_IDLE;
    end
  end

  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && !PWRITE;
  assign PREADY  = 1'b1;
  always_comb begin
    mapped  = 1'b1;
    rd_data = 32'h00000000;
    case (PADDR)
      ADDR_MODE:       rd_data = {24'h000000, mode_reg};
      ADDR_CTRL:       rd_data = {16'h0000, ctrl_reg};
      ADDR_STATUS:     rd_data = {16'h0000, STATUS_WORD};
      ADDR_PERIOD:     rd_data = {16'h0000, period_reg};
      ADDR_TIME_INDEX: rd_data = {24'h000000, index_reg};
      ADDR_TARGET:     rd_data = target_reg;
      ADDR_MAX_TORQUE: rd_data = max_torque_reg;
      ADDR_NUMER:      rd_data = numer_reg;
      ADDR_DENOM:      rd_data = denom_reg;
      ADDR_SUBTYPE:    rd_data = {31'h00000000, subtype_reg};
      ADDR_POSITION:   rd_data = position_reg;
      ADDR_SETPOINT:   rd_data = setpoint_reg;
      ADDR_FERR_TMO:   rd_data = {16'h0000, ferr_tmo_reg};
      default:         mapped  = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !mapped;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (rd_en && !PENABLE) begin
      PRDATA <= rd_data;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_reg       <= 8'h00;
      ctrl_reg       <= 16'h0000;
      period_reg     <= PERIOD_RESET;
      index_reg      <= TIME_INDEX_RESET;
      target_reg     <= 32'h00000000;
      max_torque_reg <= 32'h00000000;
      numer_reg      <= NUMER_RESET;
      denom_reg      <= DENOM_RESET;
      subtype_reg    <= 1'b0;
      ferr_tmo_reg   <= FERR_TMO_RESET;
    end else if (wr_en) begin
      case (PADDR)
        ADDR_MODE:       mode_reg       <= PWDATA[7:0];
        ADDR_CTRL:       ctrl_reg       <= PWDATA[15:0];
        ADDR_PERIOD:     period_reg     <= PWDATA[15:0];
        // any other time base is refused, keeping the 1 ms base
        ADDR_TIME_INDEX: index_reg      <= (PWDATA[7:0] == TIME_INDEX_MS) ? PWDATA[7:0] : index_reg;
        ADDR_TARGET:     target_reg     <= PWDATA;
        ADDR_MAX_TORQUE: max_torque_reg <= PWDATA;
        ADDR_NUMER:      numer_reg      <= PWDATA;
        // a zero denominator would make the width undefined
        ADDR_DENOM:      denom_reg      <= (PWDATA == 32'h00000000) ? denom_reg : PWDATA;
        ADDR_SUBTYPE:    subtype_reg    <= PWDATA[0];
        ADDR_FERR_TMO:   ferr_tmo_reg   <= PWDATA[15:0];
        default:         ctrl_reg       <= ctrl_reg;
      endcase
    end
  end

  // 1 ms base, then period in ms gives the cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ms_cnt_reg <= 32'h00000000;
    end else if (ms_cnt_reg == 32'(MS_CYCLES - 1)) begin
      ms_cnt_reg <= 32'h00000000;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 32'h00000001;
    end
  end
  assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cyc_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      cyc_cnt_reg <= cyc_tick ? 16'h0000 : cyc_cnt_reg + 16'h0001;
    end
  end
  assign cyc_tick   = ms_tick && (cyc_cnt_reg + 16'h0001 >= period_reg);
  assign CYCLE_TICK = cyc_tick;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pulse_sync_reg <= 2'b00;
      dir_sync_reg   <= 2'b00;
      bsync_sync_reg <= 2'b00;
      lneg_sync_reg  <= 2'b00;
      lpos_sync_reg  <= 2'b00;
      fout_sync_reg  <= 2'b00;
      pulse_d_reg    <= 1'b0;
      dir_d_reg      <= 1'b0;
    end else begin
      pulse_sync_reg <= {pulse_sync_reg[0], PULSE_IN};
      dir_sync_reg   <= {dir_sync_reg[0], DIR_IN};
      bsync_sync_reg <= {bsync_sync_reg[0], BUS_SYNC};
      lneg_sync_reg  <= {lneg_sync_reg[0], LIMIT_NEG};
      lpos_sync_reg  <= {lpos_sync_reg[0], LIMIT_POS};
      fout_sync_reg  <= {fout_sync_reg[0], FERR_OUTSIDE};
      pulse_d_reg    <= pulse_sync_reg[1];
      dir_d_reg      <= dir_sync_reg[1];
    end
  end

  // rising edges only; the source keeps rate and direction spacing
  always_comb begin
    if (subtype_reg) begin
      step_ev.step = (pulse_sync_reg[1] && !pulse_d_reg) || (dir_sync_reg[1] && !dir_d_reg);
      step_ev.dir  = dir_sync_reg[1] && !dir_d_reg;
    end else begin
      step_ev.step = pulse_sync_reg[1] && !pulse_d_reg;
      step_ev.dir  = dir_sync_reg[1];
    end
  end

  assign LIMIT_STOP = (mode_st == CSM_CST || mode_st == CSM_STEP) &&
                      (lneg_sync_reg[1] || lpos_sync_reg[1]);
  assign width_next = numer_reg / denom_reg;

  // 512 units per full step, so brushless poles map to 4 steps each
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      frac_reg <= 32'h00000000;
    end else if (mode_st == CSM_STEP && step_ev.step && !LIMIT_STOP) begin
      frac_reg <= step_ev.dir ? frac_reg - width_next : frac_reg + width_next;
    end
  end
  assign position_reg = frac_reg;

  // cyclic setpoint latched at a cycle tick only after a target write; torque taken against max
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      written_reg        <= 1'b0;
      setpoint_reg       <= 32'h00000000;
      setpoint_valid_reg <= 1'b0;
      follow_reg         <= 1'b0;
      in_sync_reg        <= 1'b0;
    end else begin
      setpoint_valid_reg <= 1'b0;
      in_sync_reg        <= bsync_sync_reg[1];
      if (wr_en && PADDR == ADDR_TARGET) begin
        written_reg <= 1'b1;
      end else if (cyc_tick) begin
        written_reg <= 1'b0;
      end
      if (cyc_tick) begin
        follow_reg <= (mode_st == CSM_CSV || mode_st == CSM_CST) && written_reg &&
                      !(mode_st == CSM_CST && target_reg > max_torque_reg);
        if ((mode_st == CSM_CSV || mode_st == CSM_CST) && written_reg) begin
          setpoint_reg       <= target_reg;
          setpoint_valid_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ferr_cnt_reg <= 16'h0000;
      ferr_reg     <= 1'b0;
    end else if (mode_st != CSM_STEP || !closed_loop || !fout_sync_reg[1]) begin
      ferr_cnt_reg <= 16'h0000;
      ferr_reg     <= 1'b0;
    end else if (ms_tick) begin
      if (ferr_cnt_reg >= ferr_tmo_reg) begin
        ferr_reg <= 1'b1;
      end else begin
        ferr_cnt_reg <= ferr_cnt_reg + 16'h0001;
      end
    end
  end

  always_comb begin
    STATUS_WORD = 16'h0000;
    if (mode_st == CSM_CSV || mode_st == CSM_CST) begin
      STATUS_WORD[SW_SYNC]   = in_sync_reg;
      STATUS_WORD[SW_FOLLOW] = follow_reg;
    end else if (mode_st == CSM_STEP) begin
      STATUS_WORD[SW_FERR] = ferr_reg;
    end
  end

  assign MODE           = mode_st;
  assign SETPOINT       = setpoint_reg;
  assign SETPOINT_VALID = setpoint_valid_reg;
  assign POSITION       = position_reg;

  chk_step_moves: assert property (@(posedge CLK) disable iff (RST)
    (mode_st == CSM_STEP && step_ev.step && !LIMIT_STOP && !step_ev.dir && !(wr_en))
    |=> frac_reg == $past(frac_reg) + $past(width_next)) else $error("step did not advance");
  chk_torque_needs_loop: assert property (@(posedge CLK) disable iff (RST)
    (mode_reg == MODE_CST && !closed_loop) |-> mode_st == CSM_IDLE) else $error("torque without loop");
  chk_index_fixed: assert property (@(posedge CLK) disable iff (RST)
    index_reg == TIME_INDEX_MS) else $error("time index changed");
  // sync bit lags the synchroniser by one register stage
  chk_sync_bit: assert property (@(posedge CLK) disable iff (RST)
    (mode_st == CSM_CSV || mode_st == CSM_CST) |-> STATUS_WORD[SW_SYNC] == $past(bsync_sync_reg[1]))
    else $error("sync bit wrong");
  chk_follow_idle: assert property (@(posedge CLK) disable iff (RST)
    (mode_st == CSM_IDLE) |-> !STATUS_WORD[SW_FOLLOW]) else $error("follow outside cyclic");
  chk_limit_stop: assert property (@(posedge CLK) disable iff (RST)
    (mode_st == CSM_STEP && lneg_sync_reg[1]) |-> LIMIT_STOP) else $error("limit ignored");
  chk_setpoint_load: assert property (@(posedge CLK) disable iff (RST)
    SETPOINT_VALID |-> $past(cyc_tick) && SETPOINT == $past(target_reg)) else $error("setpoint load");
  chk_ferr_clear: assert property (@(posedge CLK) disable iff (RST)
    (mode_st == CSM_STEP && !fout_sync_reg[1]) |=> !ferr_reg) else $error("ferr stuck");
endmodule : csm_top
`default_nettype wire

// File: csm_pulse_src.sv
// pulse and direction source standing in for the upstream positioning controller
`default_nettype none
module csm_pulse_src
  import csm_pkg::*;
#(
  parameter int HIGH_CYC = 50,
  parameter int LOW_CYC  = 200,
  parameter int REV_CYC  = 8750
) (
  input  wire logic      clk,
  output var  csm_step_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_rev = 1'b0;
  initial pins_o = '0;
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cyc
  // 50 high plus 200 low is 1 us, never faster than the pin allows
  task automatic fire(input logic on_dir);
    @(posedge clk);
    if (on_dir) pins_o.dir <= 1'b1; else pins_o.step <= 1'b1;
    wait_cyc(HIGH_CYC);
    if (on_dir) pins_o.dir <= 1'b0; else pins_o.step <= 1'b0;
    wait_cyc(LOW_CYC);
  endtask : fire
  task automatic step_dir(input int n, input logic d);
    if (pins_o.dir !== d) begin
      @(posedge clk);
      pins_o.dir <= d;
      wait_cyc(REV_CYC);
    end
    repeat (n) fire(1'b0);
  endtask : step_dir
  task automatic cw_ccw(input int n, input logic rev);
    if (rev !== last_rev) wait_cyc(REV_CYC);
    last_rev = rev;
    repeat (n) fire(rev);
  endtask : cw_ccw
endmodule : csm_pulse_src
`default_nettype wire

// File: csm_top_tb_top.sv
// self-checking bench for the mode block: apb, cyclic status and step counting
`default_nettype none
module csm_top_tb_top
  import csm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, setpoint, position, exp_pos;
  logic        pready, pslverr, setpoint_valid, cycle_tick, limit_stop;
  logic        bus_sync = 1'b0, limit_neg = 1'b0, limit_pos = 1'b0, ferr_outside = 1'b0;
  logic [1:0]  mode;
  logic [15:0] status_word;
  csm_step_t   pins;
  int          miscompares = 0, n_checks = 0, n_ticks = 0;
  always #2 clk = ~clk;
  // the whole run is far shorter than one 1 ms base, so no cycle may fire
  always @(negedge clk) if (cycle_tick || setpoint_valid) n_ticks++;
  csm_top csm_top_i (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .PULSE_IN(pins.step), .DIR_IN(pins.dir), .BUS_SYNC(bus_sync), .LIMIT_NEG(limit_neg),
    .LIMIT_POS(limit_pos), .FERR_OUTSIDE(ferr_outside), .MODE(mode), .STATUS_WORD(status_word),
    .SETPOINT(setpoint), .SETPOINT_VALID(setpoint_valid), .CYCLE_TICK(cycle_tick),
    .LIMIT_STOP(limit_stop), .POSITION(position));
  csm_pulse_src csm_pulse_src_i (.clk(clk), .pins_o(pins));
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk32(q, exp);
  endtask : rd_chk
  task automatic t_reset_vals;
    rd_chk(ADDR_NUMER, NUMER_RESET);
    rd_chk(ADDR_DENOM, DENOM_RESET);
    rd_chk(ADDR_TIME_INDEX, {24'h0, TIME_INDEX_MS});
    rd_chk(ADDR_PERIOD, {16'h0, PERIOD_RESET});
    rd_chk(ADDR_POSITION, 32'h0);
  endtask : t_reset_vals
  task automatic t_modes;
    wr(ADDR_MODE, {24'h0, MODE_CSV});
    bus_sync <= 1'b1;
    @(negedge clk);
    chk32(mode, CSM_CSV);
    // two sync stages plus the status register before bit 8 follows
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk32(status_word & 16'h3500, 16'h0100);
    wr(ADDR_TARGET, 32'h0000_1234);
    rd_chk(ADDR_SETPOINT, 32'h0);
    wr(ADDR_CTRL, 32'hffff_fffe);
    bus_sync <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk32({mode, status_word}, {CSM_CSV, 16'h0000});
    wr(ADDR_MODE, {24'h0, MODE_CST});
    @(negedge clk);
    chk32(mode, CSM_IDLE);
    wr(ADDR_CTRL, 32'h0000_0001);
    limit_neg <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk32({mode, limit_stop}, {CSM_CST, 1'b1});
    @(posedge clk);
    limit_neg <= 1'b0;
    wr(ADDR_MODE, {24'h0, MODE_STEP});
    @(negedge clk);
    chk32(mode, CSM_STEP);
  endtask : t_modes
  task automatic t_refuse;
    logic [31:0] q;
    logic        e;
    wr(ADDR_TIME_INDEX, 32'h0000_00fe);
    rd_chk(ADDR_TIME_INDEX, {24'h0, TIME_INDEX_MS});
    wr(ADDR_DENOM, 32'h0);
    rd_chk(ADDR_DENOM, DENOM_RESET);
    apb(1'b0, 12'h0fc, 32'h0, q, e);
    chk32(e, 1'b1);
    apb(1'b1, 12'h0f8, 32'h5, q, e);
    chk32(e, 1'b1);
  endtask : t_refuse
  // quarter steps first, then half steps backwards after the reversal gap
  task automatic t_step_dir;
    exp_pos = 32'h0000_0000;
    csm_pulse_src_i.step_dir(3, 1'b0);
    exp_pos = exp_pos + 32'd384;
    chk32(position, exp_pos);
    wr(ADDR_NUMER, 32'd512);
    wr(ADDR_DENOM, 32'd2);
    csm_pulse_src_i.step_dir(2, 1'b1);
    exp_pos = exp_pos - 32'd512;
    chk32(position, exp_pos);
    rd_chk(ADDR_POSITION, exp_pos);
    csm_pulse_src_i.step_dir(0, 1'b0);
    limit_pos <= 1'b1;
    csm_pulse_src_i.step_dir(1, 1'b0);
    chk32({31'h0, limit_stop}, 32'h1);
    chk32(position, exp_pos);
    limit_pos <= 1'b0;
  endtask : t_step_dir
  task automatic t_cw_ccw;
    wr(ADDR_SUBTYPE, 32'h1);
    csm_pulse_src_i.cw_ccw(2, 1'b0);
    exp_pos = exp_pos + 32'd512;
    chk32(position, exp_pos);
    csm_pulse_src_i.cw_ccw(1, 1'b1);
    exp_pos = exp_pos - 32'd256;
    chk32(position, exp_pos);
  endtask : t_cw_ccw
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // the step tests dominate, about 28.5k cycles; the 80k-cycle limit leaves nearly three times that
  initial begin
    #320000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk32({pready, 10'h0, status_word, setpoint_valid, cycle_tick, limit_stop, mode}, {1'b1, 31'h0});
    chk32(position, 32'h0);
    t_reset_vals();
    t_modes();
    t_refuse();
    t_step_dir();
    t_cw_ccw();
    chk32(32'(n_ticks), 32'h0);
    chk32(setpoint, 32'h0);
    tally_and_finish();
  end
endmodule : csm_top_tb_top
`default_nettype wire
